// file: dv/stofm_safety_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural safety unit driving one axis and reading its feedback
module stofm_safety_unit (
  // Clock
  input wire logic clk,
  // Guard state and fault injection
  input wire logic guard_open,
  input wire logic stuck_ch1,
  // Feedback from the drive
  input wire logic monitor_in,
  // Shutoff channels, low = off
  output logic ch1_n,
  output logic ch2_n,
  // Start inhibited and failure seen
  output logic inhibit,
  output logic fail_seen
);
  int on_cnt; // Cycles since channels went on

  // Power-up state: channels on, no failure
  initial begin
    ch1_n = 1'h1;
    ch2_n = 1'h1;
    inhibit = 1'h0;
    fail_seen = 1'h0;
    on_cnt = 0;
  end

  // Acts on the falling edge, away from the drive's sampling edge
  always @(negedge clk) begin
    if (guard_open) begin
      // A stuck channel stays on
      ch1_n <= stuck_ch1;
      ch2_n <= 1'h0;
      inhibit <= 1'h1;
    end else if (inhibit && monitor_in) begin
      // Feedback seen, release both channels
      ch1_n <= 1'h1;
      ch2_n <= 1'h1;
      inhibit <= 1'h0;
    end else if (inhibit) begin
      // No feedback: stay blocked, note failure
      fail_seen <= 1'h1;
    end
    // Settle count before feedback is judged
    if (inhibit) begin
      on_cnt <= 0;
    end else if (on_cnt < 16) begin
      on_cnt <= on_cnt + 1;
    end
    // Feedback must be off while running
    if (on_cnt == 16 && monitor_in) begin
      fail_seen <= 1'h1;
    end
  end
endmodule
`default_nettype wire

// file: dv/tb_safe_torque_off_fault_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Bench for the two-axis shutoff monitor
module tb_safe_torque_off_fault_monitor;
  localparam int FILT = 8; // Shortened off filter
  localparam int ALM = 50; // Shortened alarm count
  localparam int W_M1 = 0; // Wait selector: axis 1 monitor
  localparam int W_M2 = 1; // Wait selector: axis 2 monitor
  localparam int W_A1 = 2; // Wait selector: axis 1 alarm
  logic clk, resetn, guard, stuck, c21, c22, run1, run2, clr;
  logic c11, c12, inh, fail;
  logic m1, m2, b1, b2, e1, e2, a1, a2;
  int miscompares, checks_done;

  // Far side of axis 1
  stofm_safety_unit su (.clk(clk), .guard_open(guard), .stuck_ch1(stuck),
    .monitor_in(m1), .ch1_n(c11), .ch2_n(c12), .inhibit(inh),
    .fail_seen(fail));

  stofm_top #(.OFF_FILT_CYC(FILT), .ALARM_CYC(ALM)) uut (.clk(clk),
    .resetn(resetn), .shutoff_request_ch1_n(c11),
    .shutoff_request_ch2_n(c12), .shutoff_request_ch1_n_axis2(c21),
    .shutoff_request_ch2_n_axis2(c22), .motor_run_req(run1),
    .motor_run_req_axis2(run2), .alarm_clear(clr),
    .shutoff_fault_monitor_out(m1), .shutoff_fault_monitor_out_axis2(m2),
    .hard_wired_torque_block(b1), .hard_wired_torque_block_axis2(b2),
    .motor_enable(e1), .motor_enable_axis2(e2),
    .dual_channel_timing_alarm(a1), .dual_channel_timing_alarm_axis2(a2));

  // 200 MHz clock
  initial begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // Closing report
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compare one flag
  task automatic chk(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", what, exp, got);
    end
  endtask

  // Compare a cycle count against a window
  task automatic chk_rng(input string what, input int lo, input int hi,
      input int got);
    checks_done++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("mismatch %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  // Idle cycles
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Bounded wait for a high level, counting falling edges
  task automatic wait_hi(input int sel, input int lim, output int n);
    logic s;
    n = 0;
    s = 1'h0;
    do begin
      @(negedge clk);
      n++;
      // Pick the watched output
      if (sel == W_M1) begin
        s = m1;
      end else if (sel == W_M2) begin
        s = m2;
      end else begin
        s = a1;
      end
    end while (s !== 1'h1 && n < lim);
    if (s !== 1'h1) begin
      miscompares++;
      $display("mismatch wait expected 1 seen %b", s);
      results();
    end
  endtask

  // All four channel combinations on axis 2
  task automatic t_truth();
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      {c21, c22} <= c;
      cyc(20);
      chk("monitor_axis2", c == 2'h0, m2);
      chk("block_axis2", c != 2'h3, b2);
      chk("enable_axis2", c == 2'h3, e2);
      chk("monitor_axis1", 1'h0, m1);
      chk("block_axis1", 1'h0, b1);
    end
    $display("test truth done");
  endtask

  // Short pulse ignored, then both-off latency
  task automatic t_filter();
    int n;
    c21 <= 1'h0;
    cyc(FILT);
    c21 <= 1'h1;
    repeat (8) begin
      cyc(1);
      chk("block_pulse", 1'h0, b2);
    end
    {c21, c22} <= 2'h0;
    wait_hi(W_M2, 100, n);
    chk_rng("monitor_latency", FILT + 2, FILT + 5, n);
    {c21, c22} <= 2'h3;
    cyc(10);
    $display("test filter done");
  endtask

  // Guard cycle through the safety unit
  task automatic t_guard();
    int n;
    guard <= 1'h1;
    wait_hi(W_M1, 100, n);
    chk("block_axis1", 1'h1, b1);
    chk("enable_axis1", 1'h0, e1);
    chk("alarm_axis1", 1'h0, a1);
    guard <= 1'h0;
    cyc(20);
    chk("unit_ch1", 1'h1, c11);
    chk("monitor_run", 1'h0, m1);
    chk("enable_run", 1'h1, e1);
    run1 <= 1'h0;
    cyc(3);
    chk("enable_norun", 1'h0, e1);
    run1 <= 1'h1;
    cyc(20);
    chk("unit_fail", 1'h0, fail);
    $display("test guard done");
  endtask

  // One channel stuck on: alarm, refused restart, recovery
  task automatic t_stuck();
    int n;
    stuck <= 1'h1;
    guard <= 1'h1;
    wait_hi(W_A1, 200, n);
    chk_rng("alarm_latency", ALM, ALM + FILT + 12, n);
    chk("monitor_split", 1'h0, m1);
    chk("block_split", 1'h1, b1);
    chk("alarm_axis2", 1'h0, a2);
    guard <= 1'h0;
    clr <= 1'h1;
    cyc(1);
    clr <= 1'h0;
    cyc(4);
    chk("alarm_held", 1'h1, a1);
    chk("unit_inhibit", 1'h1, inh);
    chk("unit_fail", 1'h1, fail);
    stuck <= 1'h0;
    guard <= 1'h1;
    wait_hi(W_M1, 100, n);
    guard <= 1'h0;
    cyc(20);
    clr <= 1'h1;
    cyc(1);
    clr <= 1'h0;
    cyc(2);
    chk("alarm_cleared", 1'h0, a1);
    chk("enable_back", 1'h1, e1);
    $display("test stuck done");
  endtask

  // Main sequence
  initial begin
    miscompares = 0;
    checks_done = 0;
    resetn = 1'h0;
    {guard, stuck, clr} = 3'h0;
    {c21, c22, run1, run2} = 4'hF;
    cyc(5);
    chk("block_in_reset", 1'h1, b1);
    chk("monitor_in_reset", 1'h0, m1);
    resetn <= 1'h1;
    cyc(8);
    chk("block_after_reset", 1'h0, b1);
    chk("enable_after_reset", 1'h1, e1);
    t_truth();
    t_filter();
    t_guard();
    t_stuck();
    results();
  end
endmodule
`default_nettype wire

// file: rtl/stofm_ch_filter.sv
`timescale 1ns/1ps
`default_nettype none
// Rejects short off pulses on one shutoff channel
module stofm_ch_filter #(
  parameter int FILT_CYC = stofm_pkg::OFF_FILT_CYC,
  parameter int CNT_W = $clog2(FILT_CYC + 1)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Channel
  stofm_ch_if.filt ch
);

  localparam logic [CNT_W-1:0] FILT_MAX = CNT_W'(FILT_CYC);

  logic [CNT_W-1:0] low_cnt_r; // Cycles the channel has been low
  logic off_r; // Recognised off state

  // Low-time counter, saturates at the filter length
  always_ff @(posedge clk) begin
    if (!resetn) begin
      low_cnt_r <= '0;
    end else if (ch.in_n) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != FILT_MAX) begin
      low_cnt_r <= low_cnt_r + CNT_W'(1);
    end
  end

  // Off only after more than the filter length of low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      off_r <= 1'h1;
    end else if (ch.in_n) begin
      off_r <= 1'h0;
    end else if (low_cnt_r == FILT_MAX) begin
      off_r <= 1'h1; // R10
    end
  end

  assign ch.off = off_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Short low pulse never reaches the off state
  AST_SHORT_PULSE: assert property ( // R10
    !ch.in_n && low_cnt_r != FILT_MAX && !off_r |=> !off_r
  ) else $error("off recognised before filter time");

  // Off only follows a synchronised low
  AST_SYNC_SOURCE: assert property ( // R12
    $rose(off_r) |-> $past(ch.in_n) == 1'h0
  ) else $error("off rose without synchronised low");

endmodule
`default_nettype wire

// file: rtl/stofm_top.sv
`timescale 1ns/1ps
`default_nettype none
// Dual-channel torque shutoff monitor for two axes
module stofm_top #(
  parameter int OFF_FILT_CYC = stofm_pkg::OFF_FILT_CYC,
  parameter int unsigned ALARM_CYC = stofm_pkg::ALARM_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Axis 1 shutoff request channels, low = off
  input wire logic shutoff_request_ch1_n,
  input wire logic shutoff_request_ch2_n,
  // Axis 2 shutoff request channels, low = off
  input wire logic shutoff_request_ch1_n_axis2,
  input wire logic shutoff_request_ch2_n_axis2,
  // Motor run requests from the drive sequencer
  input wire logic motor_run_req,
  input wire logic motor_run_req_axis2,
  // Alarm clear pulse, both axes
  input wire logic alarm_clear,
  // Feedback monitors to the safety unit
  output logic shutoff_fault_monitor_out,
  output logic shutoff_fault_monitor_out_axis2,
  // Blocked indications
  output logic hard_wired_torque_block,
  output logic hard_wired_torque_block_axis2,
  // Motor power enables
  output logic motor_enable,
  output logic motor_enable_axis2,
  // Channel timing alarms
  output logic dual_channel_timing_alarm,
  output logic dual_channel_timing_alarm_axis2
);

  localparam int NCH = 2 * stofm_pkg::NUM_AXES;
  localparam int AW = 32;
  localparam int HW = $clog2(OFF_FILT_CYC + 4);
  // Cycles from both synchronised lows to monitor on
  localparam int MON_LAT = OFF_FILT_CYC + 2;
  localparam logic [HW-1:0] HLP_MAX = HW'(MON_LAT);
  localparam logic [AW-1:0] ALARM_MAX = AW'(ALARM_CYC);

  // Decode of an axis's two filtered channels into a state
  function automatic stofm_pkg::stofm_state_t state_of(
    input logic off_a,
    input logic off_b
  );
    if (off_a && off_b) begin
      state_of = stofm_pkg::ST_BLOCK;
    end else if (off_a || off_b) begin
      state_of = stofm_pkg::ST_SPLIT;
    end else begin
      state_of = stofm_pkg::ST_RUN;
    end
  endfunction

  logic [NCH-1:0] pin_n; // Raw channel pins, ch1/ch2 per axis
  logic [NCH-1:0] sync1_r; // First synchroniser stage
  logic [NCH-1:0] sync2_r; // Second synchroniser stage
  logic [NCH-1:0] ch_off; // Filtered off states
  logic [1:0] run_req; // Motor run requests per axis
  stofm_pkg::stofm_state_t state_r [2]; // Axis state
  stofm_pkg::stofm_state_t state_nxt [2]; // Axis next state
  logic [AW-1:0] mis_cnt_r [2]; // Mismatch duration per axis
  logic [1:0] mon_r; // Monitor outputs
  logic [1:0] blk_r; // Blocked indications
  logic [1:0] men_r; // Motor enables
  logic [1:0] alm_r; // Timing alarms

  assign pin_n = {shutoff_request_ch2_n_axis2, shutoff_request_ch1_n_axis2,
                  shutoff_request_ch2_n, shutoff_request_ch1_n};
  assign run_req = {motor_run_req_axis2, motor_run_req};

  // Two-stage synchroniser on every channel
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_r <= {NCH{stofm_pkg::RST_CH_N}};
      sync2_r <= {NCH{stofm_pkg::RST_CH_N}};
    end else begin
      sync1_r <= pin_n; // R12
      sync2_r <= sync1_r; // R12
    end
  end

  // Pulse filter per channel
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    stofm_ch_if ch_if ();
    assign ch_if.in_n = sync2_r[c];
    assign ch_off[c] = ch_if.off;
    stofm_ch_filter #(
      .FILT_CYC(OFF_FILT_CYC)
    ) u_filt (
      .clk(clk),
      .resetn(resetn),
      .ch(ch_if.filt)
    );
  end

  // Next state of each axis from its own channels only
  always_comb begin
    for (int a = 0; a < 2; a++) begin
      state_nxt[a] = state_of(ch_off[2*a], ch_off[2*a+1]); // R9
    end
  end

  // Axis state registers
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r[0] <= stofm_pkg::ST_BLOCK;
      state_r[1] <= stofm_pkg::ST_BLOCK;
    end else begin
      state_r[0] <= state_nxt[0];
      state_r[1] <= state_nxt[1];
    end
  end

  // Monitor on only in the both-off state
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mon_r <= '0;
    end else begin
      for (int a = 0; a < 2; a++) begin
        case (state_nxt[a])
          stofm_pkg::ST_BLOCK: mon_r[a] <= 1'h1; // R1 R2
          default: mon_r[a] <= 1'h0; // R1
        endcase
      end
    end
  end

  // Block on any off channel; open connector reads as both off
  always_ff @(posedge clk) begin
    if (!resetn) begin
      blk_r <= '1;
    end else begin
      for (int a = 0; a < 2; a++) begin
        blk_r[a] <= (state_nxt[a] != stofm_pkg::ST_RUN); // R4 R7 R9
      end
    end
  end

  // Motor power only when unblocked and requested
  always_ff @(posedge clk) begin
    if (!resetn) begin
      men_r <= '0;
    end else begin
      for (int a = 0; a < 2; a++) begin
        case (state_nxt[a])
          stofm_pkg::ST_RUN: men_r[a] <= run_req[a];
          default: men_r[a] <= 1'h0; // R4 R7
        endcase
      end
    end
  end

  // Duration of a channel mismatch, saturating
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mis_cnt_r[0] <= '0;
      mis_cnt_r[1] <= '0;
    end else begin
      for (int a = 0; a < 2; a++) begin
        if (state_r[a] != stofm_pkg::ST_SPLIT) begin
          mis_cnt_r[a] <= '0;
        end else if (mis_cnt_r[a] != ALARM_MAX) begin
          mis_cnt_r[a] <= mis_cnt_r[a] + AW'(1); // R11
        end
      end
    end
  end

  // Sticky timing alarm; a new set wins over a clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alm_r <= '0;
    end else begin
      for (int a = 0; a < 2; a++) begin
        if (state_r[a] == stofm_pkg::ST_SPLIT &&
            mis_cnt_r[a] == ALARM_MAX) begin
          alm_r[a] <= 1'h1; // R11
        end else if (alarm_clear) begin
          alm_r[a] <= 1'h0;
        end
      end
    end
  end

  // Output mapping from flip-flops
  assign shutoff_fault_monitor_out = mon_r[0];
  assign shutoff_fault_monitor_out_axis2 = mon_r[1];
  assign hard_wired_torque_block = blk_r[0];
  assign hard_wired_torque_block_axis2 = blk_r[1];
  assign motor_enable = men_r[0];
  assign motor_enable_axis2 = men_r[1];
  assign dual_channel_timing_alarm = alm_r[0];
  assign dual_channel_timing_alarm_axis2 = alm_r[1];

  // Checking helper: cycles both axis-1 channels held low after sync
  logic [HW-1:0] both_low_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      both_low_r <= '0;
    end else if (sync2_r[0] || sync2_r[1]) begin
      both_low_r <= '0;
    end else if (both_low_r != HLP_MAX) begin
      both_low_r <= both_low_r + HW'(1);
    end
  end

  // Checking helper: cycles both axis-2 channels held low after sync
  logic [HW-1:0] both_low2_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      both_low2_r <= '0;
    end else if (sync2_r[2] || sync2_r[3]) begin
      both_low2_r <= '0;
    end else if (both_low2_r != HLP_MAX) begin
      both_low2_r <= both_low2_r + HW'(1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Both channels off, then monitor
  sequence s_both_off0;
    ch_off[0] && ch_off[1];
  endsequence
  sequence s_mon_on0;
    mon_r[0] && blk_r[0] && !men_r[0];
  endsequence

  AST_MON_ON: assert property ( // R1
    s_both_off0 |=> s_mon_on0
  ) else $error("monitor not on with both channels off");

  AST_MON_OFF: assert property ( // R1
    !(ch_off[2] && ch_off[3]) |=> !mon_r[1]
  ) else $error("axis 2 monitor on without both channels off");

  AST_MON_LATENCY: assert property ( // R2
    both_low_r == HLP_MAX |-> mon_r[0]
  ) else $error("monitor late after both channels low");

  AST_BLOCK_NO_DRIVE: assert property ( // R4
    blk_r[0] |-> !men_r[0]
  ) else $error("axis 1 driven while blocked");

  // Open connector must outlast the pulse filter before it blocks
  AST_OPEN_CONNECTOR: assert property ( // R7
    both_low2_r == HLP_MAX |-> !men_r[1] && blk_r[1]
  ) else $error("axis 2 torque with both inputs open");

  AST_AXIS_INDEP: assert property ( // R9
    !ch_off[0] && !ch_off[1] |=> !blk_r[0] && !mon_r[0]
  ) else $error("axis 1 blocked by other axis");

  AST_ALARM_CAUSE: assert property ( // R11
    $rose(alm_r[0]) |-> $past(mis_cnt_r[0]) == ALARM_MAX
  ) else $error("alarm raised before mismatch time");

  AST_SYNC_PATH: assert property ( // R12
    ch_off[0] && !$past(ch_off[0]) |-> $past(sync2_r[0]) == 1'h0
  ) else $error("filter used unsynchronised input");

endmodule
`default_nettype wire

// file: shared/stofm_ch_if.sv
`timescale 1ns/1ps
`default_nettype none
// One shutoff channel between synchroniser and pulse filter
interface stofm_ch_if;
  logic in_n; // Synchronised channel level, low = off
  logic off; // Filtered off state
  // Filter side
  modport filt (input in_n, output off);
  // Control side
  modport ctrl (output in_n, input off);
endinterface
`default_nettype wire

// file: shared/stofm_pkg.sv
// Functional notes
// R1 - Monitor on only when both channels off
// R2 - Monitor on within 8 ms
// R3 - Far end checks monitor pattern at power-up
// R4 - Both off: show block, never drive motor
// R5 - Far end refuses reset if monitor off
// R6 - Far end re-enables channels on feedback
// R7 - Unconnected connector means blocked, no torque
// R8 - Far end confirms monitor off in operation
// R9 - Each axis blocks and reports independently
// R10 - Off pulses of 0.5 ms ignored
// R11 - Channel mismatch over 10 s raises alarm
// R12 - Channel inputs synchronised before use
`default_nettype none
package stofm_pkg;

  // Control clock rate
  localparam int CLK_MHZ = 200;

  // Longest off interval that is still ignored, microseconds
  localparam int OFF_FILT_US = 500;
  // Longest time from both-off to monitor on, milliseconds
  localparam int MON_MAX_MS = 8;
  // Allowed skew between the two channels, seconds
  localparam int ALARM_S = 10;

  // Derived cycle counts
  localparam int OFF_FILT_CYC = OFF_FILT_US * CLK_MHZ;
  localparam int MON_MAX_CYC = MON_MAX_MS * 1000 * CLK_MHZ;
  localparam int unsigned ALARM_CYC = ALARM_S * 1000000 * CLK_MHZ;

  // Number of axes served by one block
  localparam int NUM_AXES = 2;

  // Channel level held in the synchroniser during reset (off)
  localparam logic RST_CH_N = 1'h0;

  // Per-axis shutoff state, Gray coded along run, split, block
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_SPLIT = 2'h1,
    ST_BLOCK = 2'h3
  } stofm_state_t;

endpackage
`default_nettype wire
